// ### bench/bms_flash_model.sv
// Purpose: flash memory partner answering word reads of the boot mode selector
// Assumes: one request outstanding at a time, answer after lat_i + 1 cycles
// Notes: data bus shows a toggling pattern outside the valid pulse

`timescale 1ns/10ps

module bms_flash_model (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // flash contents and answer delay control
    input wire logic [31:0] cfg_word_i,
    input wire logic good_i,
    input wire logic [3:0] lat_i,
    // read port
    input wire logic rd_req_i,
    input wire logic [31:0] rd_addr_i,
    output logic rd_valid_o,
    output logic [31:0] rd_data_o
);
    logic pend_q;
    logic [31:0] addr_q;
    int wait_n;

    function automatic logic [31:0] word_at(input logic [31:0] a);
        logic [31:0] s;
        s = 32'h0;
        for (int k = 0; k < 7; k++) begin
            s = s + 32'h1357_9BDF * 32'(k) + 32'h0246_8ACE;
        end
        if (a == bms_pkg::CONFIG_WORD_ADDR) begin
            return cfg_word_i;
        end
        if (a == bms_pkg::CHECKSUM_ADDR) begin
            return (32'h0 - s) + (good_i ? 32'h0 : 32'h1);
        end
        if (a < bms_pkg::CHECKSUM_ADDR) begin
            return 32'h1357_9BDF * a[4:2] + 32'h0246_8ACE;
        end
        return 32'hFFFF_FFFF;
    endfunction : word_at

    // answer after a chosen delay; stale data never lingers
    always @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            pend_q <= 1'b0;
            rd_valid_o <= 1'b0;
            rd_data_o <= 32'hA5A5_5A5A;
            wait_n <= 0;
        end else begin
            rd_valid_o <= 1'b0;
            rd_data_o <= ~rd_data_o;
            if (pend_q && wait_n == 0) begin
                rd_valid_o <= 1'b1;
                rd_data_o <= word_at(addr_q);
                pend_q <= 1'b0;
            end else if (pend_q) begin
                wait_n <= wait_n - 1;
            end else if (rd_req_i) begin
                pend_q <= 1'b1;
                addr_q <= rd_addr_i;
                wait_n <= int'(lat_i);
            end
        end
    end
endmodule : bms_flash_model

// ### bench/boot_mode_selector_tb.sv
// Purpose: self-checking bench for the boot mode selector
// Assumes: 200 MHz clock, inputs driven 1 ns after the rising edge
// Notes: random straps, pins and flash contents each boot

`timescale 1ns/10ps

`define CHK(got, exp) begin samples_checked++; if ((got) !== (exp)) begin \
    $display("unexpected at %0t: got %h expected %h", $time, got, exp); err_total++; end end

module boot_mode_selector_tb;
    logic clk_i, rst_i, wd, l0, l1, l12, tx, good;
    logic [7:0] ver;
    logic [1:0] pkg;
    logic [31:0] cfg, rd_addr, rd_data;
    logic [3:0] lat;
    logic line4, line4_oe, rx, rd_req, rd_valid, done, user, prog;
    int err_total, samples_checked, idx;

    bms_selector #(.SAMPLE_WAIT(64), .SETTLE(16)) u_dut (
        .clk_i(clk_i), .rst_i(rst_i), .loader_version_i(ver), .package_i(pkg),
        .watchdog_overflow_i(wd), .port0_line0_i(l0), .port0_line1_i(l1),
        .port0_line12_i(l12), .port0_line4_o(line4), .port0_line4_oe_o(line4_oe),
        .serial0_receive_o(rx), .serial0_transmit_i(tx), .rd_req_o(rd_req),
        .rd_addr_o(rd_addr), .rd_valid_i(rd_valid), .rd_data_i(rd_data),
        .done_o(done), .user_code_o(user), .prog_mode_o(prog)
    );

    bms_flash_model u_flash (
        .clk_i(clk_i), .rst_i(rst_i), .cfg_word_i(cfg), .good_i(good), .lat_i(lat),
        .rd_req_i(rd_req), .rd_addr_i(rd_addr), .rd_valid_o(rd_valid), .rd_data_o(rd_data)
    );

    // 200 MHz clock
    initial begin
        clk_i = 1'b0;
        forever #2.5 clk_i = ~clk_i;
    end

    // verdict and end of run
    task automatic close_out();
        $display("checks %0d mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : close_out

    // read order monitor: config word first, then vector words upward
    always @(posedge clk_i) begin
        if (rst_i === 1'b0 && rd_req === 1'b1) begin
            `CHK(rd_addr, idx == 0 ? bms_pkg::CONFIG_WORD_ADDR : bms_pkg::VECTOR_BASE_ADDR + 32'(4 * (idx - 1)))
            idx++;
        end
    end

    // ----------------------------------------------------------------
    // boot sequence
    // ----------------------------------------------------------------
    initial begin
        logic entry, smp, exp_prog;
        int n;
        rst_i = 1'b1; wd = 1'b0; l0 = 1'b1; l1 = 1'b1; l12 = 1'b1; tx = 1'b1; good = 1'b1;
        ver = 8'h34; pkg = 2'h1; cfg = 32'h0; lat = 4'h0;
        err_total = 0; samples_checked = 0; idx = 0;
        void'($urandom(32'h6586be42));
        for (int c = 0; c < 40; c++) begin
            @(posedge clk_i);
            #1;
            rst_i = 1'b1;
            // entry pins driven to random levels each boot
            ver = ($urandom % 2) ? 8'h34 + 8'($urandom % 3) : 8'h30 + 8'($urandom % 4);
            pkg = 2'($urandom % 3);
            wd = ($urandom % 4) == 0;
            cfg = ($urandom % 4 == 0) ? bms_pkg::NO_SAMPLE_CODE : $urandom;
            good = 1'($urandom % 2);
            l1 = 1'($urandom % 2);
            l12 = 1'($urandom % 2);
            lat = 4'($urandom % 5);
            idx = 0;
            repeat (c == 0 ? 8 : 2) @(posedge clk_i);
            #1;
            `CHK({done, user, prog, line4_oe, rd_req}, 5'h00)
            rst_i = 1'b0;
            n = 0;
            while (done !== 1'b1 && n < 300) begin
                @(posedge clk_i);
                #1;
                n++;
            end
            if (n >= 300) begin
                err_total++;
                close_out();
            end
            entry = (ver >= bms_pkg::LOADER_V13_4 && pkg != bms_pkg::PKG_8_LEAD) ? l12 : l1;
            smp = !wd && (cfg !== bms_pkg::NO_SAMPLE_CODE);
            exp_prog = (smp && !entry) || !good;
            `CHK(prog, exp_prog)
            `CHK(user, !exp_prog)
            // routing through the pins, both levels each way
            for (int k = 0; k < 4; k++) begin
                l0 = k[0];
                tx = k[1];
                repeat (3) @(posedge clk_i);
                #1;
                `CHK(rx, exp_prog ? l0 : 1'b1)
                `CHK(line4, exp_prog ? tx : 1'b1)
                `CHK(line4_oe, exp_prog)
            end
            // outcome must ignore later pin and flag changes
            l1 = ~l1;
            l12 = ~l12;
            wd = ~wd;
            repeat (4) @(posedge clk_i);
            #1;
            `CHK({done, user, prog}, {1'b1, !exp_prog, exp_prog})
            `CHK(idx, (smp && !entry) ? 1 : 9)
        end
        close_out();
    end
endmodule : boot_mode_selector_tb

// ### rtl/bms_pkg.sv
// Purpose: constants shared by the boot mode selector files
// Assumes: 200 MHz system clock
// Notes: flash words are read one 32-bit word per request

package bms_pkg;

    // ----------------------------------------------------------------
    // timing
    // ----------------------------------------------------------------
    localparam int unsigned CLK_FREQ_MHZ = 200;
    localparam int unsigned SAMPLE_MAX_US = 3000;
    // longest wait in clock cycles, exact product of microseconds and MHz
    localparam int unsigned SAMPLE_WAIT_CYC = SAMPLE_MAX_US * CLK_FREQ_MHZ;
    localparam int unsigned SETTLE_CYC = 16;

    // ----------------------------------------------------------------
    // flash locations
    // ----------------------------------------------------------------
    localparam logic [31:0] VECTOR_BASE_ADDR = 32'h0000_0000;
    localparam logic [31:0] CHECKSUM_ADDR = 32'h0000_001C;
    localparam logic [31:0] CONFIG_WORD_ADDR = 32'h0000_02FC;
    localparam int unsigned VECTOR_WORDS = 8;
    // value of the configuration word that turns entry pin sampling off, chosen freely
    localparam logic [31:0] NO_SAMPLE_CODE = 32'h5A5A_0F0F;

    // ----------------------------------------------------------------
    // retained RAM window
    // ----------------------------------------------------------------
    localparam logic [31:0] KEEP_RAM_LO = 32'h1000_0000;
    localparam logic [31:0] KEEP_RAM_HI = 32'h1000_0050;

    // ----------------------------------------------------------------
    // entry pin choice
    // ----------------------------------------------------------------
    localparam logic [7:0] LOADER_V13_4 = 8'h34;
    localparam logic [1:0] PKG_8_LEAD = 2'h0;
    localparam logic [1:0] PKG_16_LEAD = 2'h1;
    localparam logic [1:0] PKG_20_LEAD = 2'h2;

    // outcome codes
    localparam logic [1:0] OUT_NONE = 2'h0;
    localparam logic [1:0] OUT_USER = 2'h1;
    localparam logic [1:0] OUT_PROG = 2'h2;

endpackage : bms_pkg

// ### rtl/bms_selector.sv
// Purpose: decide after reset between user code and serial programming mode
// Assumes: flash answers a word read in one or more cycles via rd_valid_i
// Notes: outcome held until next reset

`timescale 1ns/10ps

module bms_selector #(
    parameter int unsigned SAMPLE_WAIT = bms_pkg::SAMPLE_WAIT_CYC,
    parameter int unsigned SETTLE = bms_pkg::SETTLE_CYC
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // device straps and status
    input wire logic [7:0] loader_version_i,
    input wire logic [1:0] package_i,
    input wire logic watchdog_overflow_i,
    // port pins
    input wire logic port0_line0_i,
    input wire logic port0_line1_i,
    input wire logic port0_line12_i,
    output logic port0_line4_o,
    output logic port0_line4_oe_o,
    // serial port side
    output logic serial0_receive_o,
    input wire logic serial0_transmit_i,
    // flash read port
    output logic rd_req_o,
    output logic [31:0] rd_addr_o,
    input wire logic rd_valid_i,
    input wire logic [31:0] rd_data_i,
    // outcome
    output logic done_o,
    output logic user_code_o,
    output logic prog_mode_o
);

    typedef enum {
        BMS_SETTLE,
        BMS_CFG_REQ,
        BMS_CFG_WAIT,
        BMS_SAMPLE,
        BMS_SUM_REQ,
        BMS_SUM_WAIT,
        BMS_CHECK,
        BMS_DONE
    } bms_state_e;

    bms_state_e state_q;
    bms_state_e state_d;
    logic [23:0] wait_q;
    logic [3:0] word_q;
    logic no_sample_q;
    logic wdog_q;
    logic [7:0] ver_q;
    logic [1:0] pkg_q;
    logic [1:0] outcome_q;
    logic [1:0] outcome_d;
    logic [31:0] sum;
    logic line1_sync;
    logic line12_sync;
    logic line0_sync;

    // --------------------------------------------------------------
    // pin synchronisers
    // --------------------------------------------------------------
    bms_sync #(.RESET_VAL(1'b1)) u_sync_l1 (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .async_i(port0_line1_i),
        .sync_o(line1_sync)
    );
    bms_sync #(.RESET_VAL(1'b1)) u_sync_l12 (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .async_i(port0_line12_i),
        .sync_o(line12_sync)
    );
    bms_sync #(.RESET_VAL(1'b1)) u_sync_l0 (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .async_i(port0_line0_i),
        .sync_o(line0_sync)
    );

    // --------------------------------------------------------------
    // decode
    // --------------------------------------------------------------
    // entry pin choice
    wire new_loader = (ver_q >= bms_pkg::LOADER_V13_4);
    wire use_line12 = new_loader && (pkg_q != bms_pkg::PKG_8_LEAD);
    wire entry_pin = use_line12 ? line12_sync : line1_sync;
    // low pin asks for programming mode
    wire prog_request = ~entry_pin;
    wire settled = (wait_q == 24'(SETTLE));
    wire sample_late = (wait_q >= 24'(SAMPLE_WAIT - 1));
    wire code_valid = (sum == 32'h0000_0000);
    wire cfg_hit = rd_valid_i && (state_q == BMS_CFG_WAIT);
    wire sum_add = rd_valid_i && (state_q == BMS_SUM_WAIT);
    wire sum_clear = (state_q == BMS_SETTLE);
    wire last_word = (word_q == 4'(bms_pkg::VECTOR_WORDS - 1));

    bms_sum #(.WIDTH(32)) u_sum (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .clear_i(sum_clear),
        .add_i(sum_add),
        .word_i(rd_data_i),
        .sum_o(sum)
    );

    // --------------------------------------------------------------
    // next state
    // --------------------------------------------------------------
    // sequence always restarts from reset
    always_comb begin
        state_d = state_q;
        outcome_d = outcome_q;
        case (state_q)
            BMS_SETTLE: begin
                if (settled) begin
                    state_d = BMS_CFG_REQ;
                end
            end
            BMS_CFG_REQ: begin
                state_d = BMS_CFG_WAIT;
            end
            BMS_CFG_WAIT: begin
                if (rd_valid_i) begin
                    state_d = BMS_SAMPLE;
                end
            end
            BMS_SAMPLE: begin
                if (wdog_q || no_sample_q) begin
                    state_d = BMS_SUM_REQ;
                end else if (prog_request) begin
                    state_d = BMS_DONE;
                    outcome_d = bms_pkg::OUT_PROG;
                end else begin
                    state_d = BMS_SUM_REQ;
                end
            end
            BMS_SUM_REQ: begin
                state_d = BMS_SUM_WAIT;
            end
            BMS_SUM_WAIT: begin
                if (rd_valid_i) begin
                    state_d = last_word ? BMS_CHECK : BMS_SUM_REQ;
                end
            end
            BMS_CHECK: begin
                // run user code or fall back
                state_d = BMS_DONE;
                outcome_d = code_valid ? bms_pkg::OUT_USER : bms_pkg::OUT_PROG;
            end
            BMS_DONE: begin
                state_d = BMS_DONE;
            end
            default: begin
                state_d = BMS_SETTLE;
            end
        endcase
    end

    // --------------------------------------------------------------
    // state and counters
    // --------------------------------------------------------------
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            state_q <= BMS_SETTLE;
            outcome_q <= bms_pkg::OUT_NONE;
        end else begin
            state_q <= state_d;
            outcome_q <= outcome_d;
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            wait_q <= '0;
        end else if (!sample_late) begin
            wait_q <= wait_q + 24'h00_0001;
        end
    end

    // straps caught on every clock while in BMS_SETTLE, not by the reset
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            ver_q <= 8'h00;
            pkg_q <= 2'h0;
            wdog_q <= 1'b0;
        end else if (state_q == BMS_SETTLE) begin
            ver_q <= loader_version_i;
            pkg_q <= package_i;
            wdog_q <= watchdog_overflow_i;
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            no_sample_q <= 1'b0;
        end else if (cfg_hit) begin
            no_sample_q <= (rd_data_i == bms_pkg::NO_SAMPLE_CODE);
        end
    end

    // word index into the vector table
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            word_q <= '0;
        end else if (sum_add) begin
            word_q <= word_q + 4'h1;
        end
    end

    // --------------------------------------------------------------
    // flash reads
    // --------------------------------------------------------------
    // only flash addresses are ever issued, RAM stays untouched
    assign rd_req_o = (state_q == BMS_CFG_REQ) || (state_q == BMS_SUM_REQ);
    assign rd_addr_o = (state_q == BMS_CFG_REQ) ? bms_pkg::CONFIG_WORD_ADDR
                     : bms_pkg::VECTOR_BASE_ADDR + {26'h0, word_q, 2'h0};

    // --------------------------------------------------------------
    // outputs
    // --------------------------------------------------------------
    // registered outcome
    assign done_o = (outcome_q != bms_pkg::OUT_NONE);
    assign user_code_o = (outcome_q == bms_pkg::OUT_USER);
    assign prog_mode_o = (outcome_q == bms_pkg::OUT_PROG);

    // pin routing in programming mode, transmit idles high otherwise
    assign serial0_receive_o = prog_mode_o ? line0_sync : 1'b1;
    assign port0_line4_o = prog_mode_o ? serial0_transmit_i : 1'b1;
    assign port0_line4_oe_o = prog_mode_o;

    // --------------------------------------------------------------
    // checks
    // --------------------------------------------------------------
    a_outcome_stable: assert property (
        @(posedge clk_i) disable iff (rst_i)
        done_o |=> ($stable(outcome_q) && done_o))
        else $error("outcome changed after decision");

    a_pin_prog: assert property (
        @(posedge clk_i) disable iff (rst_i)
        (state_q == BMS_SAMPLE && !wdog_q && !no_sample_q && prog_request) |=> prog_mode_o)
        else $error("low entry pin did not select programming");

    a_wdog_skip: assert property (
        @(posedge clk_i) disable iff (rst_i)
        (state_q == BMS_SAMPLE && wdog_q) |=> state_q == BMS_SUM_REQ)
        else $error("watchdog did not skip pin");

    a_cfg_skip: assert property (
        @(posedge clk_i) disable iff (rst_i)
        (state_q == BMS_SAMPLE && no_sample_q) |=> !done_o)
        else $error("disabled pin sampling still decided");

    a_pin_high: assert property (
        @(posedge clk_i) disable iff (rst_i)
        (state_q == BMS_SAMPLE && !wdog_q && !no_sample_q && !prog_request) |=> state_q == BMS_SUM_REQ)
        else $error("high pin did not start search");

    a_code_check: assert property (
        @(posedge clk_i) disable iff (rst_i)
        (state_q == BMS_CHECK) |=> (user_code_o == $past(code_valid)) && (prog_mode_o != $past(code_valid)))
        else $error("wrong outcome after checksum");

    a_tx_route: assert property (
        @(posedge clk_i) disable iff (rst_i)
        prog_mode_o |-> (port0_line4_oe_o && port0_line4_o == serial0_transmit_i))
        else $error("transmit not routed");

    a_pin_select: assert property (
        @(posedge clk_i) disable iff (rst_i)
        (ver_q < bms_pkg::LOADER_V13_4 || pkg_q == bms_pkg::PKG_8_LEAD) |-> entry_pin == line1_sync)
        else $error("wrong entry pin chosen");

    a_ram_untouched: assert property (
        @(posedge clk_i) disable iff (rst_i)
        rd_req_o |-> !(rd_addr_o >= bms_pkg::KEEP_RAM_LO && rd_addr_o <= bms_pkg::KEEP_RAM_HI))
        else $error("read in retained window");

    a_sample_from_reset: assert property (
        @(posedge clk_i) disable iff (rst_i)
        (state_q == BMS_SETTLE) |-> !done_o)
        else $error("decision before sequence");

    a_sample_time: assert property (
        @(posedge clk_i) disable iff (rst_i)
        (state_q == BMS_SAMPLE && !wdog_q && !no_sample_q) |=> (prog_mode_o == $past(prog_request)))
        else $error("sampled pin level not obeyed");

    a_sample_deadline: assert property (
        @(posedge clk_i) disable iff (rst_i)
        sample_late |-> (state_q != BMS_SETTLE && state_q != BMS_CFG_REQ && state_q != BMS_CFG_WAIT))
        else $error("entry pin not sampled in time");

endmodule : bms_selector

// ### rtl/bms_sum.sv
// Purpose: running 32-bit sum of vector table words
// Assumes: words arrive one per valid pulse
// Notes: wraps modulo two to the thirty-second

`timescale 1ns/10ps

module bms_sum #(
    parameter int unsigned WIDTH = 32
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // control
    input wire logic clear_i,
    input wire logic add_i,
    input wire logic [WIDTH-1:0] word_i,
    // result
    output logic [WIDTH-1:0] sum_o
);

    // --------------------------------------------------------------
    // accumulator, carry out dropped on purpose
    // --------------------------------------------------------------
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            sum_o <= '0;
        end else if (clear_i) begin
            sum_o <= '0;
        end else if (add_i) begin
            sum_o <= sum_o + word_i;
        end
    end

endmodule : bms_sum

// ### rtl/bms_sync.sv
// Purpose: two flip-flop synchroniser for a pin level
// Assumes: one clock, asynchronous active high reset
// Notes: first stage is read only by the second stage

`timescale 1ns/10ps

module bms_sync #(
    parameter logic RESET_VAL = 1'b1
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // level
    input wire logic async_i,
    output logic sync_o
);

    logic meta_q;

    // --------------------------------------------------------------
    // two stages
    // --------------------------------------------------------------
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            meta_q <= RESET_VAL;
            sync_o <= RESET_VAL;
        end else begin
            meta_q <= async_i;
            sync_o <= meta_q;
        end
    end

endmodule : bms_sync
